// ==== src/bpr_port.v ====
`timescale 1ns/100ps
`default_nettype none
`include "bpr_defines.vh"

module bpr_port #(
    parameter WIDTH                      = `BPR_DEF_WIDTH,
    parameter AW                         = `BPR_DEF_DEPTH_LOG2,
    parameter [WIDTH-1:0] RST_VAL        = `BPR_DEF_RST_VAL,
    parameter PORT_A_FULL_RESET_OPTION   = 1,
    parameter PORT_B_FULL_RESET_OPTION   = 1,
    parameter PORT_A_RESET_FIRST         = 0,
    parameter PORT_B_RESET_FIRST         = 0,
    parameter PORT_A_HAS_OUTREG          = 1,
    parameter PORT_B_HAS_OUTREG          = 1,
    parameter [1:0] ERROR_INJECTION_SELECT = `BPR_INJ_NONE,
    parameter FABRIC_ECC_OPTION          = 0,
    parameter FABRIC_ECC_INPUT_STAGE     = 0,
    parameter EN_ECC_PIPE                = 0,
    parameter EN_SLEEP_PIN               = 0,
    parameter PORT_A_READ_ADDR_COMPARE   = 0,
    parameter PORT_B_READ_ADDR_COMPARE   = 0
) (
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire             i_ce,
    // Port A
    input  wire             i_a_en,
    input  wire             i_a_we,
    input  wire [AW-1:0]    i_a_addr,
    input  wire [WIDTH-1:0] i_a_wdata,
    input  wire             i_a_outreg_ce,
    input  wire             i_a_rst,
    input  wire             i_a_inj_sbit,
    input  wire             i_a_inj_dbit,
    output reg  [WIDTH-1:0] o_a_rdata,
    // Port B
    input  wire             i_b_en,
    input  wire             i_b_we,
    input  wire [AW-1:0]    i_b_addr,
    input  wire [WIDTH-1:0] i_b_wdata,
    input  wire             i_b_outreg_ce,
    input  wire             i_b_rst,
    output reg  [WIDTH-1:0] o_b_rdata,
    // Options
    input  wire             i_sleep,
    input  wire             i_ecc_pipe_ce,
    output reg              o_sbit_err,
    output reg              o_dbit_err,
    output reg              o_a_rst_busy,
    output reg              o_b_rst_busy
);

// ----------------------------------------------------------------
// Option decode
// ----------------------------------------------------------------
wire sleep_w   = (EN_SLEEP_PIN == 1) ? i_sleep : 1'b0;
wire pipe_ce_w = (EN_ECC_PIPE == 1) ? i_ecc_pipe_ce : 1'b1;
wire inj_s_ok  = (ERROR_INJECTION_SELECT == `BPR_INJ_SBIT) ||
                 (ERROR_INJECTION_SELECT == `BPR_INJ_BOTH);
wire inj_d_ok  = (ERROR_INJECTION_SELECT == `BPR_INJ_DBIT) ||
                 (ERROR_INJECTION_SELECT == `BPR_INJ_BOTH);
wire in_stage  = (FABRIC_ECC_OPTION == 1) &&
                 (FABRIC_ECC_INPUT_STAGE == 1);
wire a_cmp_on  = (PORT_A_READ_ADDR_COMPARE == 1);
wire b_cmp_on  = (PORT_B_READ_ADDR_COMPARE == 1);

// ----------------------------------------------------------------
// Port A input stage
// ----------------------------------------------------------------
reg             a_en_r;
reg             a_we_r;
reg  [AW-1:0]   a_addr_r;
reg  [WIDTH-1:0] a_wdata_r;
reg             a_inj_s_r;
reg             a_inj_d_r;

always @(posedge i_clk) begin
    if (!i_rst_n) begin
        a_en_r    <= 1'b0;
        a_we_r    <= 1'b0;
        a_addr_r  <= {AW{1'b0}};
        a_wdata_r <= {WIDTH{1'b0}};
        a_inj_s_r <= 1'b0;
        a_inj_d_r <= 1'b0;
    end else if (i_ce) begin
        a_en_r    <= i_a_en;
        a_we_r    <= i_a_we;
        a_addr_r  <= i_a_addr;
        a_wdata_r <= i_a_wdata;
        a_inj_s_r <= i_a_inj_sbit;
        a_inj_d_r <= i_a_inj_dbit;
    end
end

// ----------------------------------------------------------------
// Port B input stage
// ----------------------------------------------------------------
reg             b_en_r;
reg             b_we_r;
reg  [AW-1:0]   b_addr_r;
reg  [WIDTH-1:0] b_wdata_r;

always @(posedge i_clk) begin
    if (!i_rst_n) begin
        b_en_r    <= 1'b0;
        b_we_r    <= 1'b0;
        b_addr_r  <= {AW{1'b0}};
        b_wdata_r <= {WIDTH{1'b0}};
    end else if (i_ce) begin
        b_en_r    <= i_b_en;
        b_we_r    <= i_b_we;
        b_addr_r  <= i_b_addr;
        b_wdata_r <= i_b_wdata;
    end
end

wire             a_en    = (in_stage ? a_en_r    : i_a_en) & ~sleep_w;
wire             a_we    = in_stage ? a_we_r    : i_a_we;
wire [AW-1:0]    a_addr  = in_stage ? a_addr_r  : i_a_addr;
wire [WIDTH-1:0] a_wdata = in_stage ? a_wdata_r : i_a_wdata;
wire             a_inj_s = (in_stage ? a_inj_s_r : i_a_inj_sbit) & inj_s_ok;
wire             a_inj_d = (in_stage ? a_inj_d_r : i_a_inj_dbit) & inj_d_ok;
wire             b_en    = (in_stage ? b_en_r    : i_b_en) & ~sleep_w;
wire             b_we    = in_stage ? b_we_r    : i_b_we;
wire [AW-1:0]    b_addr  = in_stage ? b_addr_r  : i_b_addr;
wire [WIDTH-1:0] b_wdata = in_stage ? b_wdata_r : i_b_wdata;

// ----------------------------------------------------------------
// Reset and enable priority
// ----------------------------------------------------------------
wire a_gate = (PORT_A_HAS_OUTREG == 1) ? i_a_outreg_ce : a_en;
wire b_gate = (PORT_B_HAS_OUTREG == 1) ? i_b_outreg_ce : b_en;
// Reset first: reset acts alone; enable first: reset needs the enable
reg  a_rst_act;
reg  b_rst_act;

always @* begin
    if (PORT_A_RESET_FIRST == 1) begin
        a_rst_act = i_a_rst;
    end else begin
        a_rst_act = i_a_rst & a_gate;
    end
end

always @* begin
    if (PORT_B_RESET_FIRST == 1) begin
        b_rst_act = i_b_rst;
    end else begin
        b_rst_act = i_b_rst & b_gate;
    end
end
wire a_full = (PORT_A_FULL_RESET_OPTION == 1);
wire b_full = (PORT_B_FULL_RESET_OPTION == 1);

// ----------------------------------------------------------------
// Memory array and latches
// ----------------------------------------------------------------
reg  [WIDTH-1:0] mem [0:(1<<AW)-1];
reg  [WIDTH-1:0] a_latch_r;
reg  [WIDTH-1:0] b_latch_r;
wire [WIDTH-1:0] a_flip = {{(WIDTH-2){1'b0}}, a_inj_d, a_inj_s | a_inj_d};

always @(posedge i_clk) begin
    if (i_ce) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_wdata ^ a_flip;
        end
        if (b_en && b_we) begin
            mem[b_addr] <= b_wdata;
        end
    end
end

localparam [1:0] HOLD_LOAD = `BPR_RST_HOLD_CYC - 2'h1;

// ----------------------------------------------------------------
// Port A latch next state
// ----------------------------------------------------------------
wire [WIDTH-1:0] a_mem_rd = mem[a_addr];
reg  [WIDTH-1:0] a_latch_nxt;

always @* begin
    a_latch_nxt = a_latch_r;
    if (a_rst_act && a_full) begin
        a_latch_nxt = RST_VAL;
    end else if (a_en && !(a_cmp_on && a_rst_act)) begin
        a_latch_nxt = a_mem_rd;
    end
end

// ----------------------------------------------------------------
// Port B latch next state
// ----------------------------------------------------------------
wire [WIDTH-1:0] b_mem_rd = mem[b_addr];
reg  [WIDTH-1:0] b_latch_nxt;

always @* begin
    b_latch_nxt = b_latch_r;
    if (b_rst_act && b_full) begin
        b_latch_nxt = RST_VAL;
    end else if (b_en && !(b_cmp_on && b_rst_act)) begin
        b_latch_nxt = b_mem_rd;
    end
end

// ----------------------------------------------------------------
// Port A latch register
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        a_latch_r <= RST_VAL;
    end else if (i_ce) begin
        a_latch_r <= a_latch_nxt;
    end
end

// ----------------------------------------------------------------
// Port B latch register
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        b_latch_r <= RST_VAL;
    end else if (i_ce) begin
        b_latch_r <= b_latch_nxt;
    end
end

// ----------------------------------------------------------------
// Output state
// ----------------------------------------------------------------
reg  [1:0] a_hold_r;
reg  [1:0] b_hold_r;
reg        inj_s_r;
reg        inj_d_r;

// ----------------------------------------------------------------
// Port A output next state
// ----------------------------------------------------------------
reg  [WIDTH-1:0] a_rdata_nxt;
reg  [1:0]       a_hold_nxt;
reg              a_busy_nxt;

always @* begin
    a_rdata_nxt = o_a_rdata;
    a_hold_nxt  = a_hold_r;
    a_busy_nxt  = 1'b0;
    if (a_rst_act) begin
        a_rdata_nxt = RST_VAL;
        a_hold_nxt  = a_full ? HOLD_LOAD : 2'h0;
        a_busy_nxt  = 1'b1;
    end else if (a_hold_r != 2'h0) begin
        a_rdata_nxt = RST_VAL;
        a_hold_nxt  = a_hold_r - 2'h1;
        a_busy_nxt  = 1'b1;
    end else if (a_gate) begin
        a_rdata_nxt = a_latch_r;
    end
end

// ----------------------------------------------------------------
// Port B output next state
// ----------------------------------------------------------------
reg  [WIDTH-1:0] b_rdata_nxt;
reg  [1:0]       b_hold_nxt;
reg              b_busy_nxt;

always @* begin
    b_rdata_nxt = o_b_rdata;
    b_hold_nxt  = b_hold_r;
    b_busy_nxt  = 1'b0;
    if (b_rst_act) begin
        b_rdata_nxt = RST_VAL;
        b_hold_nxt  = b_full ? HOLD_LOAD : 2'h0;
        b_busy_nxt  = 1'b1;
    end else if (b_hold_r != 2'h0) begin
        b_rdata_nxt = RST_VAL;
        b_hold_nxt  = b_hold_r - 2'h1;
        b_busy_nxt  = 1'b1;
    end else if (b_gate) begin
        b_rdata_nxt = b_latch_r;
    end
end

// ----------------------------------------------------------------
// Port A output registers
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        o_a_rdata    <= RST_VAL;
        a_hold_r     <= 2'h0;
        o_a_rst_busy <= 1'b0;
    end else if (i_ce) begin
        o_a_rdata    <= a_rdata_nxt;
        a_hold_r     <= a_hold_nxt;
        o_a_rst_busy <= a_busy_nxt;
    end
end

// ----------------------------------------------------------------
// Port B output registers
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        o_b_rdata    <= RST_VAL;
        b_hold_r     <= 2'h0;
        o_b_rst_busy <= 1'b0;
    end else if (i_ce) begin
        o_b_rdata    <= b_rdata_nxt;
        b_hold_r     <= b_hold_nxt;
        o_b_rst_busy <= b_busy_nxt;
    end
end

// ----------------------------------------------------------------
// Error injection first stage
// ----------------------------------------------------------------
wire inj_s_nxt = a_en & a_we & a_inj_s & ~a_inj_d;
wire inj_d_nxt = a_en & a_we & a_inj_d;

always @(posedge i_clk) begin
    if (!i_rst_n) begin
        inj_s_r <= 1'b0;
        inj_d_r <= 1'b0;
    end else if (i_ce && pipe_ce_w) begin
        inj_s_r <= inj_s_nxt;
        inj_d_r <= inj_d_nxt;
    end
end

// ----------------------------------------------------------------
// Error injection flags
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (!i_rst_n) begin
        o_sbit_err <= 1'b0;
        o_dbit_err <= 1'b0;
    end else if (i_ce && pipe_ce_w) begin
        o_sbit_err <= inj_s_r;
        o_dbit_err <= inj_d_r;
    end
end

endmodule // bpr_port

`default_nettype wire

// ==== src/bpr_defines.vh ====
`ifndef BPR_DEFINES_VH
`define BPR_DEFINES_VH

// Option encodings
`define BPR_OPT_OFF          1'b0
`define BPR_OPT_ON           1'b1
`define BPR_PRIO_CE          1'b0
`define BPR_PRIO_SR          1'b1
`define BPR_INJ_NONE         2'h0
`define BPR_INJ_SBIT         2'h1
`define BPR_INJ_DBIT         2'h2
`define BPR_INJ_BOTH         2'h3
// Reset value hold length in cycles
`define BPR_RST_HOLD_CYC     2'h2
// Defaults
`define BPR_DEF_WIDTH        8
`define BPR_DEF_DEPTH_LOG2   4
`define BPR_DEF_RST_VAL      8'h00

`endif

// ==== sim/bpr_port_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module bpr_port_properties #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RST_VAL = 0
) (
    // Watched ports
    input wire i_clk, i_rst_n, i_ce, i_a_en, i_a_we,
    input wire i_a_outreg_ce, i_a_rst, i_a_inj_sbit, i_a_inj_dbit,
    input wire i_b_rst, o_sbit_err, o_dbit_err, o_a_rst_busy,
    input wire o_b_rst_busy,
    input wire [WIDTH-1:0] o_a_rdata, o_b_rdata
);
    // ----------------
    // Checks
    // ----------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_ra; i_ce && i_a_rst && i_a_outreg_ce; endsequence
    sequence s_rb; i_ce && i_b_rst; endsequence
    sequence s_ws;
        i_ce && i_a_en && i_a_we && i_a_inj_sbit && !i_a_inj_dbit;
    endsequence
    sequence s_wd; i_ce && i_a_en && i_a_we && i_a_inj_dbit; endsequence
    chk_a_rst_val: assert property (
        s_ra |=> o_a_rst_busy && o_a_rdata == RST_VAL)
        else $error("a reset value");
    chk_a_rst_hold: assert property (
        s_ra ##1 (i_ce && !i_a_rst) |=> o_a_rst_busy && o_a_rdata == RST_VAL)
        else $error("a reset hold");
    chk_a_rst_end: assert property (
        s_ra ##1 (i_ce && !i_a_rst) [*2] |=> !o_a_rst_busy)
        else $error("a reset too long");
    chk_b_rst_first: assert property (
        s_rb |=> o_b_rst_busy && o_b_rdata == RST_VAL)
        else $error("b reset first");
    chk_b_rst_short: assert property (
        s_rb ##1 (i_ce && !i_b_rst) |=> !o_b_rst_busy)
        else $error("b reset too long");
    chk_a_ce_first: assert property (
        i_ce && i_a_rst && !i_a_outreg_ce && !o_a_rst_busy
        |=> $stable(o_a_rdata)) else $error("a enable first");
    chk_inj_single: assert property (
        s_ws ##1 i_ce |=> o_sbit_err) else $error("sbit flag");
    chk_inj_double: assert property (
        s_wd ##1 i_ce |=> o_dbit_err) else $error("dbit flag");
endmodule // bpr_port_properties
bind bpr_port bpr_port_properties #(.WIDTH(WIDTH), .RST_VAL(RST_VAL)) u_p (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_a_en(i_a_en),
    .i_a_we(i_a_we), .i_a_outreg_ce(i_a_outreg_ce), .i_a_rst(i_a_rst),
    .i_a_inj_sbit(i_a_inj_sbit), .i_a_inj_dbit(i_a_inj_dbit),
    .i_b_rst(i_b_rst), .o_sbit_err(o_sbit_err), .o_dbit_err(o_dbit_err),
    .o_a_rst_busy(o_a_rst_busy), .o_b_rst_busy(o_b_rst_busy),
    .o_a_rdata(o_a_rdata), .o_b_rdata(o_b_rdata));
`default_nettype wire

// ==== sim/bpr_fabric_b.sv ====
`timescale 1ns/100ps
`default_nettype none
module bpr_fabric_b (
    // Commands
    input  wire       i_clk,
    input  wire [1:0] i_cmd,
    input  wire [3:0] i_addr,
    input  wire       i_hold,
    // Port B pins
    output reg        o_en, o_we, o_rst, o_ce,
    output reg  [3:0] o_addr,
    output reg  [7:0] o_wdata
);
    initial {o_en, o_we, o_rst, o_ce, o_addr, o_wdata} = 16'h105a;
    always @(posedge i_clk) begin
        o_en <= (i_cmd == 2'h1);
        o_we <= 1'b0;
        o_rst <= (i_cmd == 2'h2);
        o_ce <= ~i_hold;
        o_addr <= (i_cmd == 2'h1) ? i_addr : ~o_addr;
        o_wdata <= ~o_wdata;
    end
endmodule // bpr_fabric_b
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clk = 0, rst_n = 0, a_en = 0, a_we = 0, a_ce = 1, a_rst = 0;
    logic inj_s = 0, inj_d = 0, b_hold = 0, due_a = 0, due_b = 0;
    logic ce = 1, slp = 0, pce = 1;
    logic [3:0] a_addr = 0, b_ad = 0;
    logic [7:0] a_wd = 0, d, mem[16], q_a[$], q_b[$];
    logic [1:0] b_cmd = 0;
    wire b_en, b_we, b_rst, b_ce, sb, db, ab, bb;
    wire [3:0] b_addr;
    wire [7:0] b_wd, a_rd, b_rd;
    integer errors = 0, comparisons = 0, seed = 95, n;
    always #25 i_clk = ~i_clk;
    bpr_fabric_b u_fab (.i_clk(i_clk), .i_cmd(b_cmd), .i_addr(b_ad),
        .i_hold(b_hold), .o_en(b_en), .o_we(b_we), .o_rst(b_rst),
        .o_ce(b_ce), .o_addr(b_addr), .o_wdata(b_wd));
    bpr_port #(.PORT_B_FULL_RESET_OPTION(0), .PORT_B_RESET_FIRST(1),
        .ERROR_INJECTION_SELECT(2'h3)) dut (.i_clk(i_clk),
        .i_rst_n(rst_n), .i_ce(ce), .i_a_en(a_en), .i_a_we(a_we),
        .i_a_addr(a_addr), .i_a_wdata(a_wd), .i_a_outreg_ce(a_ce),
        .i_a_rst(a_rst), .i_a_inj_sbit(inj_s), .i_a_inj_dbit(inj_d),
        .o_a_rdata(a_rd), .i_b_en(b_en), .i_b_we(b_we), .i_b_addr(b_addr),
        .i_b_wdata(b_wd), .i_b_outreg_ce(b_ce), .i_b_rst(b_rst),
        .o_b_rdata(b_rd), .i_sleep(slp), .i_ecc_pipe_ce(pce),
        .o_sbit_err(sb), .o_dbit_err(db), .o_a_rst_busy(ab),
        .o_b_rst_busy(bb));
    task automatic cmp(input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr_a(input logic [3:0] a, input logic [7:0] v,
                        input logic s, input logic t);
        @(posedge i_clk) {a_en, a_we, a_addr, a_wd, inj_s, inj_d} <=
            {2'h3, a, v, s, t};
        @(posedge i_clk) {a_en, a_we, inj_s, inj_d} <= 4'h0;
    endtask
    task automatic rd_a(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk) {a_en, a_we, a_addr} <= {2'h2, a};
        q_a.push_back(e);
        @(posedge i_clk) a_en <= 0;
        @(posedge i_clk) due_a <= 1;
        @(posedge i_clk) due_a <= 0;
    endtask
    task automatic rd_b(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk) {b_cmd, b_ad} <= {2'h1, a};
        q_b.push_back(e);
        @(posedge i_clk) b_cmd <= 0;
        repeat (2) @(posedge i_clk);
        due_b <= 1;
        @(posedge i_clk) due_b <= 0;
    endtask
    // ----------------
    // Result watcher
    // ----------------
    always @(negedge i_clk) begin
        if (due_a) cmp(q_a.pop_front(), a_rd);
        if (due_b) cmp(q_b.pop_front(), b_rd);
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        errors++;
        tally_and_finish;
    end
    // ----------------
    // Scenarios
    // ----------------
    initial begin
        repeat (10) @(posedge i_clk);
        rst_n <= 1;
        for (n = 0; n < 16; n++) begin
            mem[n] = $random(seed);
            wr_a(n[3:0], mem[n], 0, 0);
        end
        for (n = 0; n < 16; n++) rd_a(n[3:0], mem[n]);
        for (n = 0; n < 3; n++) begin
            d = $random(seed);
            wr_a(4'h2, d, n[0], n[1]);
            rd_a(4'h2, d ^ {6'h0, n[1], n[0] | n[1]});
        end
        @(posedge i_clk) {a_ce, a_rst} <= 2'h1;
        @(posedge i_clk) {a_ce, a_rst} <= 2'h3;
        @(posedge i_clk) {a_rst, due_a} <= 2'h3;
        repeat (4) q_a.push_back(8'h00);
        @(posedge i_clk) a_rst <= 0;
        repeat (3) @(posedge i_clk);
        due_a <= 0;
        rd_b(4'h7, mem[7]);
        @(posedge i_clk) {b_cmd, b_hold} <= 3'h5;
        @(posedge i_clk) {b_cmd, b_hold} <= 3'h0;
        q_b.push_back(8'h00);
        q_b.push_back(mem[7]);
        @(posedge i_clk) due_b <= 1;
        repeat (2) @(posedge i_clk);
        due_b <= 0;
        @(posedge i_clk) ce <= 0;
        wr_a(4'h3, ~mem[3], 0, 0);
        ce <= 1;
        rd_a(4'h3, mem[3]);
        repeat (4) @(posedge i_clk);
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
